// File: common/tcc_defines.svh
// Register offsets, field positions and reset values for the timer compare channel control block.
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ****************************************************************
// Register indices; the byte address on the bus is four times the index.
// ****************************************************************
`define TCC_IDX_MODE_SEL     6'h00
`define TCC_IDX_FORCE        6'h01
`define TCC_IDX_OVR_MASK     6'h02
`define TCC_IDX_OVR_DATA     6'h03
`define TCC_IDX_OVF_TOGGLE   6'h07
`define TCC_IDX_PIN_ACTION   6'h08
`define TCC_IDX_CH5_HIGH     6'h1a
`define TCC_IDX_CH5_LOW      6'h1b
`define TCC_IDX_CH6_HIGH     6'h1c
`define TCC_IDX_CH6_LOW      6'h1d
`define TCC_IDX_CH7_HIGH     6'h1e
`define TCC_IDX_CH7_LOW      6'h1f
`define TCC_IDX_PA_CONTROL   6'h20
`define TCC_IDX_PA_FLAGS     6'h21
`define TCC_IDX_PA_CNT_HIGH  6'h22
`define TCC_IDX_PA_CNT_LOW   6'h23
`define TCC_IDX_TIMER_TEST   6'h2d
`define TCC_IDX_INT_STATUS   6'h30
`define TCC_IDX_INT_MASK     6'h31

// ****************************************************************
// Field layout and reset values.
// ****************************************************************
`define TCC_CH_HI            7
`define TCC_CH_LO            4
`define TCC_CH7              3
`define TCC_NIB_RST          4'h0
`define TCC_BYTE_RST         8'h00
`define TCC_WORD_RST         32'h0000_0000
`define TCC_ACT_NONE         2'h0
`define TCC_ACT_TOGGLE       2'h1
`define TCC_ACT_CLEAR        2'h2
`define TCC_ACT_SET          2'h3

`endif

// File: common/tcc_pkg.sv
// Types shared by the timer compare channel control block.
package tcc_pkg;

  // Whole register state of the control block, held in one flop bank.
  typedef struct packed {
    logic [3:0]  sel;        // Capture (0) or compare (1) per channel.
    logic [3:0]  mask;       // Channel 7 override mask.
    logic [3:0]  data;       // Channel 7 override data.
    logic [3:0]  tov;        // Toggle on overflow enables.
    logic [7:0]  pinact;     // Mode and level pairs per channel.
    logic [3:0]  ists;       // Sticky compare flags.
    logic [3:0]  imsk;       // Interrupt enables.
    logic [3:0]  force_pls;  // One-cycle forced action pulses.
    logic [3:0]  pin;        // Port data driven onto the pins.
    logic [3:0]  oe;         // Port direction, high drives.
    logic        irq;        // Interrupt level.
    logic        pready;     // APB ready.
    logic        pslverr;    // APB error.
    logic [31:0] prdata;     // APB read data.
  } tcc_state_t;

  typedef logic [7:0] tcc_addr_t;

endpackage

// File: core/tcc_channel_ctrl.sv
// Channel mode, forced compare and channel 7 override control with an APB register slave.
//
// Contract
// - Select bit 0 makes a channel capture, 1 makes it compare.
// - Reads of the force register always return zero.
// - Writing a force bit as one performs that channel's compare pin action.
// - A forced action equals a real match but sets no interrupt flag.
// - Force and real match together: forced action wins, flag stays clear.
// - A channel 7 compare overrides simultaneous channel 6 to 4 actions on masked channels.
// - A set mask bit makes the pin an output only in compare mode.
// - On channel 7 compare, masked compare channels copy their override data bit.
// - Select, mask and data registers are readable and writable anytime.
// - Mode and level actions drive a pin only while its mask bit clears.
// - Overflow toggle beats forced action but yields to channel 7 override.
//
// Register map: one field per 32-bit word; the byte address is four times the index.
// Index 0x00 selects capture or compare per channel in bits 7:4.
// Index 0x01 forces compare actions; it is write only and always reads zero.
// Index 0x02 holds the channel 7 override mask in bits 7:4.
// Index 0x03 holds the channel 7 override data in bits 7:4.
// Index 0x07 enables the overflow toggle per channel in bits 7:4.
// Index 0x08 holds a mode and level pair per channel, channel 4 in bits 1:0.
// Index 0x30 holds the sticky match flags in bits 7:4; writing a one clears a flag.
// Index 0x31 enables the interrupt per flag in bits 7:4.
// Every other index answers with an error and ignores writes, since the counter,
// capture and pulse accumulator words belong to neighbouring blocks.
// A transfer is answered in its first access cycle, so the bus never waits.
// A force write lands at the edge that ends its access; the action pulse stands
// in the next cycle and the pin moves at the edge after that, which keeps the
// force path identical to a counter match and avoids a second pin update path.
// A hardware flag set wins over a software clear in the same cycle, so no
// match can be lost to a clear that raced it.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defines.svh"

module tcc_channel_ctrl (
  input  wire logic             core_clk,   // Bus clock, 125 MHz.
  input  wire logic             rst,        // Synchronous reset, active high.
  input  wire logic             psel,       // APB select.
  input  wire logic             penable,    // APB enable.
  input  wire logic             pwrite,     // APB direction, high writes.
  input  wire tcc_pkg::tcc_addr_t paddr,    // APB byte address.
  input  wire logic [31:0]      pwdata,     // APB write data.
  output logic [31:0]           prdata,     // APB read data.
  output logic                  pready,     // APB ready.
  output logic                  pslverr,    // APB error on unmapped address.
  input  wire logic [3:0]       cmp_match,  // Counter match pulse per channel 4..7.
  input  wire logic             cnt_ovf,    // Counter overflow pulse.
  output logic [3:0]            pin_out,    // Port data for channels 4..7.
  output logic [3:0]            pin_oe,     // Port output enable for channels 4..7.
  output logic                  irq         // Level interrupt.
);
  import tcc_pkg::*;

  // ****************************************************************
  // State.
  // ****************************************************************
  tcc_state_t s_r;
  tcc_state_t s_nxt;

  logic       setup;
  logic       wr_acc;
  logic [5:0] idx;
  logic       hit;
  logic [7:0] rd_byte;
  logic [3:0] ev;
  logic       ev7;
  logic [3:0] ists_set;
  logic [3:0] ists_clr;
  logic [1:0] act;

  // Bus phase decode; the access is answered in its first access cycle.
  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & s_r.pready & pwrite;
  assign idx    = paddr[7:2];

  // Register read multiplexer; unmapped indices flag an error.
  always_comb begin
    hit     = 1'b1;
    rd_byte = `TCC_BYTE_RST;
    case (idx)
      `TCC_IDX_MODE_SEL: begin
        rd_byte = {s_r.sel, `TCC_NIB_RST};
      end
      `TCC_IDX_FORCE: begin
        rd_byte = `TCC_BYTE_RST;
      end
      `TCC_IDX_OVR_MASK: begin
        rd_byte = {s_r.mask, `TCC_NIB_RST};
      end
      `TCC_IDX_OVR_DATA: begin
        rd_byte = {s_r.data, `TCC_NIB_RST};
      end
      `TCC_IDX_OVF_TOGGLE: begin
        rd_byte = {s_r.tov, `TCC_NIB_RST};
      end
      `TCC_IDX_PIN_ACTION: begin
        rd_byte = s_r.pinact;
      end
      `TCC_IDX_INT_STATUS: begin
        rd_byte = {s_r.ists, `TCC_NIB_RST};
      end
      `TCC_IDX_INT_MASK: begin
        rd_byte = {s_r.imsk, `TCC_NIB_RST};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // Compare events.
  // ****************************************************************
  // A forced pulse counts as a match in compare mode only, so capture channels ignore it.
  assign ev  = (cmp_match | s_r.force_pls) & s_r.sel;
  assign ev7 = ev[`TCC_CH7];

  // Real matches flag only where no forced pulse coincides, so force keeps the flag clear.
  assign ists_set = cmp_match & s_r.sel & ~s_r.force_pls;
  assign ists_clr = (wr_acc && idx == `TCC_IDX_INT_STATUS) ? pwdata[`TCC_CH_HI:`TCC_CH_LO] : 4'h0;

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb begin
    s_nxt           = s_r;
    act             = `TCC_ACT_NONE;
    s_nxt.force_pls = 4'h0;
    // Ready rises with the setup cycle and so stands for exactly the first access cycle.
    s_nxt.pready    = setup;
    if (setup) begin
      s_nxt.pslverr = ~hit;
      s_nxt.prdata  = pwrite ? `TCC_WORD_RST : {24'h00_0000, rd_byte};
    end
    // Register writes take effect at the edge where the access completes.
    if (wr_acc) begin
      case (idx)
        `TCC_IDX_MODE_SEL: begin
          s_nxt.sel = pwdata[`TCC_CH_HI:`TCC_CH_LO];
        end
        `TCC_IDX_FORCE: begin
          s_nxt.force_pls = pwdata[`TCC_CH_HI:`TCC_CH_LO];
        end
        `TCC_IDX_OVR_MASK: begin
          s_nxt.mask = pwdata[`TCC_CH_HI:`TCC_CH_LO];
        end
        `TCC_IDX_OVR_DATA: begin
          s_nxt.data = pwdata[`TCC_CH_HI:`TCC_CH_LO];
        end
        `TCC_IDX_OVF_TOGGLE: begin
          s_nxt.tov = pwdata[`TCC_CH_HI:`TCC_CH_LO];
        end
        `TCC_IDX_PIN_ACTION: begin
          s_nxt.pinact = pwdata[7:0];
        end
        `TCC_IDX_INT_MASK: begin
          s_nxt.imsk = pwdata[`TCC_CH_HI:`TCC_CH_LO];
        end
        default: begin
          s_nxt.imsk = s_r.imsk;
        end
      endcase
    end
    // A hardware set in the same cycle as a software clear keeps the flag.
    s_nxt.ists = (s_r.ists & ~ists_clr) | ists_set;
    s_nxt.irq  = |(s_nxt.ists & s_nxt.imsk);
    // Per-channel pin logic, in falling priority: override, overflow toggle, own action.
    for (int n = 0; n < 4; n++) begin
      act        = s_r.pinact[2*n+:2];
      s_nxt.oe[n] = s_r.sel[n] & (s_r.mask[n] | (|act));
      if (ev7 && s_r.mask[n] && s_r.sel[n]) begin
        s_nxt.pin[n] = s_r.data[n];
      end else if (cnt_ovf && s_r.tov[n] && s_r.sel[n]) begin
        s_nxt.pin[n] = ~s_r.pin[n];
      end else if (ev[n] && !s_r.mask[n]) begin
        case (act)
          `TCC_ACT_TOGGLE: begin
            s_nxt.pin[n] = ~s_r.pin[n];
          end
          `TCC_ACT_CLEAR: begin
            s_nxt.pin[n] = 1'b0;
          end
          `TCC_ACT_SET: begin
            s_nxt.pin[n] = 1'b1;
          end
          default: begin
            s_nxt.pin[n] = s_r.pin[n];
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  // All control state clears on reset so pins start as inputs at low.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state flops.
  assign prdata  = s_r.prdata;
  assign pready  = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign pin_out = s_r.pin;
  assign pin_oe  = s_r.oe;
  assign irq     = s_r.irq;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  // A read of the force register answers zero.
  force_read_zero_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (setup && !pwrite && idx == `TCC_IDX_FORCE) |=> (pready && prdata == `TCC_WORD_RST))
    else $error("Force register read returned nonzero data.");

  // A completed force write produces its pulse on the next cycle.
  force_write_pulse_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_acc && idx == `TCC_IDX_FORCE) |=> (s_r.force_pls == $past(pwdata[`TCC_CH_HI:`TCC_CH_LO])))
    else $error("Force write did not produce the written pulse.");

  // A force pulse never stands for two cycles.
  force_single_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (s_r.force_pls != 4'h0) |=> (s_r.force_pls == 4'h0))
    else $error("Force pulse lasted more than one cycle.");

  // A forced channel never raises its flag, even with a real match beside it.
  force_no_flag_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (|(s_r.force_pls & ~s_r.ists)) |=> ((s_r.ists & $past(s_r.force_pls & ~s_r.ists)) == 4'h0))
    else $error("Forced compare set an interrupt flag.");

  // A real unforced match in compare mode raises its flag next cycle.
  match_flag_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (|ists_set) |=> ((s_r.ists & $past(ists_set)) == $past(ists_set)))
    else $error("Real compare match did not set its flag.");

  // Capture channels never drive their pins.
  capture_no_drive_a : assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> ((pin_oe & ~$past(s_r.sel)) == 4'h0))
    else $error("Capture channel drove its pin.");

  // A masked compare channel is always an output.
  mask_drives_a : assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> (($past(s_r.sel & s_r.mask) & ~pin_oe) == 4'h0))
    else $error("Masked compare channel was not an output.");

  // A channel 7 event copies override data into every masked compare channel.
  ch7_override_a : assert property (
    @(posedge core_clk) disable iff (rst)
    ev7 |=> (((pin_out ^ $past(s_r.data)) & $past(s_r.sel & s_r.mask)) == 4'h0))
    else $error("Channel 7 override data was not copied.");

  // Without a channel 7 event or overflow, masked pins hold their level.
  mask_blocks_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (!ev7 && !cnt_ovf) |=> (((pin_out ^ $past(pin_out)) & $past(s_r.mask)) == 4'h0))
    else $error("Own action drove a masked pin.");

  // Overflow toggle wins over a forced action when no override applies.
  ovf_toggle_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (cnt_ovf && !ev7) |=>
      (((pin_out ^ ~$past(pin_out)) & $past(s_r.tov & s_r.sel)) == 4'h0))
    else $error("Overflow toggle did not take precedence.");

  // A write to the mask register takes effect at once.
  mask_write_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_acc && idx == `TCC_IDX_OVR_MASK) |=> (s_r.mask == $past(pwdata[`TCC_CH_HI:`TCC_CH_LO])))
    else $error("Mask register write was lost.");

  // The interrupt follows the unmasked flags within one cycle.
  irq_level_a : assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> (irq == |(s_r.ists & s_r.imsk)))
    else $error("Interrupt level disagrees with flags.");

  // ****************************************************************
  // Bus and register checks.
  // ****************************************************************
  // Ready stands for one cycle only, so a master never takes a stale answer twice.
  ready_pulse_a : assert property (
    @(posedge core_clk) disable iff (rst)
    pready |=> !pready)
    else $error("Ready stood for more than one cycle.");

  // A write answers with zero read data.
  write_rdata_zero_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (setup && pwrite) |=> (pready && prdata == `TCC_WORD_RST))
    else $error("Write returned nonzero read data.");

  // An unmapped index is answered with an error in its access cycle.
  unmapped_err_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (setup && !hit) |=> (pready && pslverr))
    else $error("Unmapped access was not flagged.");

  // A write to an unmapped index leaves the select, mask, data and interrupt enable registers alone.
  unmapped_no_write_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_acc && !hit) |=> (s_r.sel == $past(s_r.sel) && s_r.mask == $past(s_r.mask)
      && s_r.data == $past(s_r.data) && s_r.imsk == $past(s_r.imsk)))
    else $error("Unmapped write changed a register.");

  // A write to the select register takes effect at once.
  sel_write_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_acc && idx == `TCC_IDX_MODE_SEL) |=> (s_r.sel == $past(pwdata[`TCC_CH_HI:`TCC_CH_LO])))
    else $error("Select register write was lost.");

  // A write to the override data register takes effect at once.
  data_write_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_acc && idx == `TCC_IDX_OVR_DATA) |=> (s_r.data == $past(pwdata[`TCC_CH_HI:`TCC_CH_LO])))
    else $error("Override data register write was lost.");

  // A written one clears its flag unless a match sets it in the same cycle.
  status_clear_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (wr_acc && idx == `TCC_IDX_INT_STATUS) |=>
      ((s_r.ists & $past(pwdata[`TCC_CH_HI:`TCC_CH_LO] & ~ists_set)) == 4'h0))
    else $error("Flag survived a clear without a new match.");

  // A new unmasked flag raises the interrupt at the edge that sets it.
  irq_rise_a : assert property (
    @(posedge core_clk) disable iff (rst)
    (|(ists_set & s_r.imsk) && !(wr_acc && idx == `TCC_IDX_INT_MASK)) |=>
      irq)
    else $error("Unmasked flag did not raise the interrupt.");

  // ****************************************************************
  // Pin checks.
  // ****************************************************************
  // A capture channel's port data never moves, whatever events arrive.
  capture_pin_hold_a : assert property (
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> (((pin_out ^ $past(pin_out)) & ~$past(s_r.sel)) == 4'h0))
    else $error("Capture channel pin moved.");

  // Per channel, an own action lands when neither override nor overflow toggle outranks it.
  // The mask must be clear for the own action to reach the pin at all.
  for (genvar g = 0; g < 4; g++) begin : g_own
    own_set_a : assert property (
      @(posedge core_clk) disable iff (rst)
      (ev[g] && !s_r.mask[g] && !(cnt_ovf && s_r.tov[g]) && s_r.pinact[2*g+:2] == `TCC_ACT_SET) |=> pin_out[g])
      else $error("Set action did not raise its pin.");
    own_clear_a : assert property (
      @(posedge core_clk) disable iff (rst)
      (ev[g] && !s_r.mask[g] && !(cnt_ovf && s_r.tov[g]) && s_r.pinact[2*g+:2] == `TCC_ACT_CLEAR) |=> !pin_out[g])
      else $error("Clear action did not lower its pin.");
    own_toggle_a : assert property (
      @(posedge core_clk) disable iff (rst)
      (ev[g] && !s_r.mask[g] && !(cnt_ovf && s_r.tov[g]) && s_r.pinact[2*g+:2] == `TCC_ACT_TOGGLE) |=>
        (pin_out[g] != $past(pin_out[g])))
      else $error("Toggle action did not flip its pin.");
  end

endmodule

`default_nettype wire

// File: tb/tcc_pin_model.sv
// Timer port pad model for channels 4 to 7.
`timescale 1ns/1ns
`default_nettype none

module tcc_pin_model (
  input  wire logic       core_clk,  // Bus clock.
  input  wire logic [3:0] pin_out,   // Port data from the block.
  input  wire logic [3:0] pin_oe,    // High where the block drives.
  output logic      [3:0] pad        // Resolved pad levels.
);
  logic [3:0] float_r = 4'h5;

  // An undriven pad has no pull, so it wanders; a stale level would hide a lost enable.
  always_ff @(posedge core_clk) begin
    float_r <= ~float_r;
  end

  // Each pad follows the block only where its enable is high.
  assign pad = (pin_out & pin_oe) | (float_r & ~pin_oe);
endmodule

`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the timer compare channel control block.
`timescale 1ns/1ns
`default_nettype none
`include "tcc_defines.svh"

module tb;
  import tcc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        cnt_ovf = 1'b0;
  tcc_addr_t   paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  cmp_match = 4'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] r;
  logic [31:0] seed = 32'h23;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  pad;
  logic [3:0]  sel;
  logic [3:0]  msk;
  logic [3:0]  dat;
  logic [3:0]  tov;
  logic [3:0]  ep;
  logic [3:0]  flg;
  logic [3:0]  im;
  logic [7:0]  act;
  int          n_errors = 0;
  int          n_tests = 0;

  tcc_channel_ctrl uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp_match(cmp_match), .cnt_ovf(cnt_ovf), .pin_out(pin_out),
    .pin_oe(pin_oe), .irq(irq));
  tcc_pin_model pads (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

  // Clock at 125 MHz.
  always #4 core_clk = ~core_clk;

  // ****************************************
  // Reference model and bus helpers.
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Priority per channel: channel 7 override, overflow toggle, own action.
  function automatic logic [3:0] nxt(logic [3:0] p, logic [3:0] e, logic o);
    for (int k = 0; k < 4; k++) begin
      if (sel[k]) begin
        if (e[3] && sel[3] && msk[k]) p[k] = dat[k];
        else if (o && tov[k]) p[k] = ~p[k];
        else if (e[k] && !msk[k])
          case (act[2*k+:2])
            2'h1: p[k] = ~p[k];
            2'h2: p[k] = 1'b0;
            2'h3: p[k] = 1'b1;
            default: p[k] = p[k];
          endcase
      end
    end
    return p;
  endfunction

  // A pin drives in compare mode when masked or given an action.
  function automatic logic [3:0] oe_x();
    logic [3:0] a;
    for (int k = 0; k < 4; k++) a[k] = |act[2*k+:2];
    return sel & (msk | a);
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // One transfer, opened one edge after the caller so strobes never change twice in a step.
  task automatic apb(logic w, logic [5:0] i, logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic wr(logic [5:0] i, logic [3:0] v);
    apb(1'b1, i, {24'h0, v, 4'h0});
  endtask

  task automatic rdc(string nm, logic [5:0] i, logic [3:0] v);
    apb(1'b0, i, 32'h0);
    chk(nm, {24'h0, v, 4'h0}, rd);
    chk("pslverr", 32'h0, 32'(err));
  endtask

  // One event cycle, from the edge it is called on; pins are looked at a cycle later.
  task automatic step(logic [3:0] e, logic [3:0] f, logic o);
    cmp_match <= e;
    cnt_ovf <= o;
    @(posedge core_clk);
    cmp_match <= 4'h0;
    cnt_ovf <= 1'b0;
    #1;
    ep = nxt(ep, e | f, o);
    flg = flg | (e & sel & ~f);
    chk("pin_out", 32'(ep), 32'(pin_out));
    chk("pad", 32'(ep & pin_oe), 32'(pad & pin_oe));
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    {sel, msk, dat, tov, act, ep, flg, im} = 36'h0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rdc("mode_sel", `TCC_IDX_MODE_SEL, 4'h0);
    rdc("ovr_mask", `TCC_IDX_OVR_MASK, 4'h0);
    chk("pin_oe", 32'h0, 32'(pin_oe));
    apb(1'b1, `TCC_IDX_CH5_HIGH, 32'hff);
    chk("unmapped", 32'h1, 32'(err));
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      {act, tov, dat, msk, sel} = r[23:0];
      wr(`TCC_IDX_MODE_SEL, sel);
      wr(`TCC_IDX_OVR_MASK, msk);
      wr(`TCC_IDX_OVR_DATA, dat);
      wr(`TCC_IDX_OVF_TOGGLE, tov);
      apb(1'b1, `TCC_IDX_PIN_ACTION, {24'h0, act});
      rdc("mode_sel", `TCC_IDX_MODE_SEL, sel);
      rdc("ovr_mask", `TCC_IDX_OVR_MASK, msk);
      rdc("ovr_data", `TCC_IDX_OVR_DATA, dat);
      chk("pin_oe", 32'(oe_x()), 32'(pin_oe));
      wr(`TCC_IDX_FORCE, r[27:24]);
      step(4'h0, r[27:24], 1'b0);
      rdc("force", `TCC_IDX_FORCE, 4'h0);
      repeat (12) begin
        @(posedge core_clk);
        r = rnd();
        step(r[3:0], 4'h0, r[4] & r[5]);
      end
      rdc("status", `TCC_IDX_INT_STATUS, flg);
      im = r[9:6];
      wr(`TCC_IDX_INT_MASK, im);
      repeat (2) @(posedge core_clk);
      #1;
      chk("irq", 32'(|(flg & im)), 32'(irq));
      wr(`TCC_IDX_INT_STATUS, 4'hf);
      flg = 4'h0;
      repeat (2) @(posedge core_clk);
      #1;
      chk("irq_clear", 32'h0, 32'(irq));
    end
    // Force, real match and overflow in one cycle: toggle beats force, no flag.
    {sel, msk, tov, act} = {4'hf, 4'h0, 4'h1, 8'h07};
    wr(`TCC_IDX_MODE_SEL, sel);
    wr(`TCC_IDX_OVR_MASK, msk);
    wr(`TCC_IDX_OVF_TOGGLE, tov);
    apb(1'b1, `TCC_IDX_PIN_ACTION, {24'h0, act});
    wr(`TCC_IDX_FORCE, 4'h3);
    step(4'h2, 4'h3, 1'b1);
    rdc("status", `TCC_IDX_INT_STATUS, 4'h0);
    repeat (2) begin
      wr(`TCC_IDX_FORCE, 4'h2);
      step(4'h0, 4'h2, 1'b0);
    end
    // Override data equal to the pin level, so a toggle that wrongly won would show.
    dat = {3'h0, ep[0]};
    wr(`TCC_IDX_OVR_DATA, dat);
    msk = 4'h1;
    wr(`TCC_IDX_OVR_MASK, msk);
    @(posedge core_clk);
    step(4'h9, 4'h0, 1'b1);
    end_of_test();
  end

  // Cut a hang short.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end
endmodule

`default_nettype wire
